// ===== logic/dcr_bank.sv
// How it works
// - write to 0AH loads diag_control; bits 1-3 unreadable
// - control bit 0 holds aux cpu reset
// - control bit 1 low blanks display
// - control bit 2 picks graphics video
// - control bit 3 enables parity test mode
// - bit 4 route select, cleared at reset
// - printer rx: line or video serial
// - printer bit clock: baud gen or 500k
// - video clock: master or 250k
// - separator: raw data or printer tx
// - routing ties test input to serial irq
// - bit 5 ring test: line tx loops back
// - ring: printer/keys transmit cross over
// - bits 6,7 store and restore settings
// - read 0AH: readback mirrors control bits 0 and 4-7
// - readback bits 1-3 show factory straps
// - read 02H: modem status lines bits 0-4
// - status bits 5-7: failure en, irqs
// - write 02H loads modem control lines
// - modem bits 4-7 drive lamps, low lit
`timescale 1ns/1ps
`default_nettype none
module dcr_bank (
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_rst_b,
  input  wire logic [7:0]              i_io_addr,
  input  wire logic [7:0]              i_io_wdata,
  input  wire logic                    i_io_wr,
  input  wire logic                    i_io_rd,
  output logic      [7:0]              o_io_rdata,
  input  wire logic [2:0]              i_factory_straps,
  input  wire dcr_pkg::dcr_modem_in_t  i_modem,
  input  wire logic                    i_hw_failure_detect_en_n,
  input  wire logic                    i_main_cpu_irq_n,
  input  wire logic                    i_aux_cpu_irq_n,
  input  wire logic                    i_serial_irq_n,
  input  wire logic                    i_test_pin_normal,
  input  wire dcr_pkg::dcr_route_in_t  i_route,
  input  wire logic                    i_printer_baud_clk,
  input  wire logic                    i_clk_500k,
  input  wire logic                    i_master_clk,
  input  wire logic                    i_clk_250k,
  input  wire logic                    i_system_video,
  input  wire logic                    i_graphics_video,
  output logic                         o_aux_cpu_hold,
  output logic                         o_video_out,
  output logic                         o_parity_test,
  output logic                         o_settings_store,
  output logic                         o_settings_restore,
  output logic                         o_diag_route_select,
  output logic                         o_printer_bit_clock,
  output logic                         o_video_clk,
  output logic                         o_main_test_in,
  output dcr_pkg::dcr_route_out_t      o_route,
  output logic                         o_line_speed_select,
  output logic                         o_line_secondary_req,
  output logic                         o_line_terminal_ready_n,
  output logic                         o_line_req_send,
  output logic      [3:0]              o_error_lamp
);

  logic [7:0]              diag_ff;
  logic [7:0]              modem_ff;
  logic [7:0]              nxt_rdata;
  dcr_pkg::dcr_route_out_t nxt_route;
  logic                    route;
  logic                    ring;

  assign route = diag_ff[dcr_pkg::DCR_DC_ROUTE];
  assign ring  = diag_ff[dcr_pkg::DCR_DC_RING];

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      diag_ff <= dcr_pkg::DCR_DIAG_RESET;
    end else if (i_io_wr && i_io_addr == dcr_pkg::DCR_ADDR_DIAG) begin
      diag_ff <= i_io_wdata;
    end
  end

  chk_diag_keep: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    !(i_io_wr && i_io_addr == dcr_pkg::DCR_ADDR_DIAG) |=> $stable(diag_ff))
    else $error("diag control changed without a write");

  chk_reset_routes: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    $rose(i_rst_b) |-> diag_ff == dcr_pkg::DCR_DIAG_RESET
                       && modem_ff == dcr_pkg::DCR_MODEM_RESET)
    else $error("registers not at reset value");

  chk_loop_cleared: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    $rose(i_rst_b) |-> !route && !ring && diag_ff[dcr_pkg::DCR_DC_AUX_HOLD])
    else $error("loopback bits not cleared by reset");

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      modem_ff <= dcr_pkg::DCR_MODEM_RESET;
    end else if (i_io_wr && i_io_addr == dcr_pkg::DCR_ADDR_MODEM) begin
      modem_ff <= i_io_wdata;
    end
  end

  chk_modem_write: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    i_io_wr && i_io_addr == dcr_pkg::DCR_ADDR_MODEM
      |=> modem_ff == $past(i_io_wdata))
    else $error("modem control not loaded");

  // modem reads return live inputs; diag reads echo written bits 7:4 and 0, straps in 3:1
  always_comb begin
    nxt_rdata = 8'h00;
    if (i_io_rd && i_io_addr == dcr_pkg::DCR_ADDR_DIAG) begin
      nxt_rdata = {diag_ff[7:4], i_factory_straps, diag_ff[0]};
    end else if (i_io_rd && i_io_addr == dcr_pkg::DCR_ADDR_MODEM) begin
      nxt_rdata = {i_aux_cpu_irq_n, i_main_cpu_irq_n,
                   i_hw_failure_detect_en_n,
                   i_modem.carrier, i_modem.clear_send,
                   i_modem.set_ready, i_modem.speed_ind,
                   i_modem.ring_ind};
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_io_rdata <= 8'h00;
    end else begin
      o_io_rdata <= nxt_rdata;
    end
  end

  // ring test takes priority over diagnostic routing on shared inputs
  always_comb begin
    nxt_route.line_rx_in = ring ? i_route.line_tx_out
                                : i_route.line_data_in;
    nxt_route.keys_rx_in = ring ? i_route.printer_tx_out
                                : i_route.keys_line_in;
    if (ring) begin
      nxt_route.printer_rx_in = i_route.keys_tx_out;
    end else if (route) begin
      nxt_route.printer_rx_in = i_route.video_serial_out;
    end else begin
      nxt_route.printer_rx_in = i_route.printer_line_in;
    end
    nxt_route.separator_in = route ? i_route.printer_tx_out
                                   : i_route.raw_drive_data;
  end

  // muxed paths carry one cycle of latency so every output is registered
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_route             <= '0;
      o_printer_bit_clock <= 1'b0;
      o_video_clk         <= 1'b0;
      o_main_test_in      <= 1'b0;
    end else begin
      o_route             <= nxt_route;
      o_printer_bit_clock <= route ? i_clk_500k : i_printer_baud_clk;
      o_video_clk         <= route ? i_clk_250k : i_master_clk;
      o_main_test_in      <= route ? i_serial_irq_n : i_test_pin_normal;
    end
  end

  chk_printer_line: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    !route && !ring
      |=> o_route.printer_rx_in == $past(i_route.printer_line_in))
    else $error("printer rx not from line");

  chk_printer_video: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    route && !ring
      |=> o_route.printer_rx_in == $past(i_route.video_serial_out))
    else $error("printer rx not from video serial");

  chk_ring_cross: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    ring |=> o_route.printer_rx_in == $past(i_route.keys_tx_out)
             && o_route.keys_rx_in == $past(i_route.printer_tx_out))
    else $error("ring crossover wrong");

  chk_ring_off: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    !ring |=> o_route.line_rx_in == $past(i_route.line_data_in)
              && o_route.keys_rx_in == $past(i_route.keys_line_in))
    else $error("receive inputs not from connectors");

  chk_sep_raw: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    !route |=> o_route.separator_in == $past(i_route.raw_drive_data))
    else $error("separator not from drive data");

  chk_printer_clock: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    route |=> o_printer_bit_clock == $past(i_clk_500k))
    else $error("printer clock not from test clock");

  chk_baud_clock: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    !route |=> o_printer_bit_clock == $past(i_printer_baud_clk))
    else $error("printer clock not from baud clock");

  chk_slow_video_clk: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    route |=> o_video_clk == $past(i_clk_250k))
    else $error("video clock not from slow clock");

  chk_test_irq: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    route |=> o_main_test_in == $past(i_serial_irq_n))
    else $error("test input not from serial irq");

  chk_test_normal: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    !route |=> o_main_test_in == $past(i_test_pin_normal))
    else $error("test input not from normal source");

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_video_out <= 1'b0;
    end else if (!diag_ff[dcr_pkg::DCR_DC_DISP_EN]) begin
      o_video_out <= 1'b0;
    end else begin
      o_video_out <= diag_ff[dcr_pkg::DCR_DC_VID_SEL] ? i_graphics_video
                                                      : i_system_video;
    end
  end

  chk_video_graphics: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    diag_ff[dcr_pkg::DCR_DC_DISP_EN] && diag_ff[dcr_pkg::DCR_DC_VID_SEL]
      |=> o_video_out == $past(i_graphics_video))
    else $error("graphics video not selected");

  chk_video_system: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    diag_ff[dcr_pkg::DCR_DC_DISP_EN] && !diag_ff[dcr_pkg::DCR_DC_VID_SEL]
      |=> o_video_out == $past(i_system_video))
    else $error("system video not selected");

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_aux_cpu_hold      <= 1'b1;
      o_parity_test       <= 1'b0;
      o_settings_store    <= 1'b0;
      o_settings_restore  <= 1'b0;
      o_diag_route_select <= 1'b0;
    end else begin
      o_aux_cpu_hold      <= diag_ff[dcr_pkg::DCR_DC_AUX_HOLD];
      o_parity_test       <= diag_ff[dcr_pkg::DCR_DC_PARITY];
      o_settings_store    <= diag_ff[dcr_pkg::DCR_DC_STORE];
      o_settings_restore  <= diag_ff[dcr_pkg::DCR_DC_RESTORE];
      o_diag_route_select <= route;
    end
  end

  chk_aux_hold: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    diag_ff[dcr_pkg::DCR_DC_AUX_HOLD] |=> o_aux_cpu_hold)
    else $error("aux cpu not held");

  chk_parity_test: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    1'h1 |=> o_parity_test == $past(diag_ff[dcr_pkg::DCR_DC_PARITY]))
    else $error("parity test output wrong");

  chk_route_flag: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    1'h1 |=> o_diag_route_select == $past(route))
    else $error("route select output wrong");

  chk_settings_strobes: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    1'h1 |=> o_settings_store == $past(diag_ff[dcr_pkg::DCR_DC_STORE])
             && o_settings_restore == $past(diag_ff[dcr_pkg::DCR_DC_RESTORE]))
    else $error("settings strobes wrong");

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_line_speed_select     <= 1'b0;
      o_line_secondary_req    <= 1'b0;
      o_line_terminal_ready_n <= 1'b1;
      o_line_req_send         <= 1'b0;
      o_error_lamp            <= 4'hF;
    end else begin
      o_line_speed_select     <= modem_ff[dcr_pkg::DCR_MC_SPEED];
      o_line_secondary_req    <= modem_ff[dcr_pkg::DCR_MC_SEC_REQ];
      o_line_terminal_ready_n <= modem_ff[dcr_pkg::DCR_MC_TERM_RDY_N];
      o_line_req_send         <= modem_ff[dcr_pkg::DCR_MC_REQ_SEND];
      o_error_lamp            <= modem_ff[7:dcr_pkg::DCR_MC_LAMP_LSB];
    end
  end

  chk_line_controls: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    1'h1 |=> {o_line_req_send, o_line_terminal_ready_n,
              o_line_secondary_req, o_line_speed_select}
             == $past(modem_ff[3:0]))
    else $error("modem line outputs wrong");

  chk_diag_write_load: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    i_io_wr && i_io_addr == dcr_pkg::DCR_ADDR_DIAG
      |-> ##2 o_aux_cpu_hold == $past(i_io_wdata[0], 2))
    else $error("aux hold does not follow diag write");

  chk_readback_mirror: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    i_io_rd && i_io_addr == dcr_pkg::DCR_ADDR_DIAG
      |=> o_io_rdata[7:4] == $past(diag_ff[7:4])
          && o_io_rdata[3:1] == $past(i_factory_straps)
          && o_io_rdata[0] == $past(diag_ff[0]))
    else $error("diag readback wrong");

  chk_modem_status: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    i_io_rd && i_io_addr == dcr_pkg::DCR_ADDR_MODEM
      |=> o_io_rdata[4:0] == {$past(i_modem.carrier),
                              $past(i_modem.clear_send),
                              $past(i_modem.set_ready),
                              $past(i_modem.speed_ind),
                              $past(i_modem.ring_ind)})
    else $error("modem status read wrong");

  chk_status_flags: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    i_io_rd && i_io_addr == dcr_pkg::DCR_ADDR_MODEM
      |=> o_io_rdata[7:5] == {$past(i_aux_cpu_irq_n),
                              $past(i_main_cpu_irq_n),
                              $past(i_hw_failure_detect_en_n)})
    else $error("status flag bits wrong");

  chk_blank_video: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    !diag_ff[dcr_pkg::DCR_DC_DISP_EN] |=> !o_video_out)
    else $error("display not blanked");

  chk_ring_line: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    ring |=> o_route.line_rx_in == $past(i_route.line_tx_out))
    else $error("line loopback wrong");

  chk_route_sep: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    route |=> o_route.separator_in == $past(i_route.printer_tx_out))
    else $error("separator source wrong");

  chk_route_clock: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    !route |=> o_video_clk == $past(i_master_clk))
    else $error("video clock source wrong");

  chk_lamp_code: assert property (@(posedge i_ref_clk)
    disable iff (!i_rst_b)
    i_io_wr && i_io_addr == dcr_pkg::DCR_ADDR_MODEM
      |-> ##2 o_error_lamp == $past(i_io_wdata[7:4], 2))
    else $error("lamp code wrong");

endmodule
`default_nettype wire

// ===== logic/dcr_pkg.sv
package dcr_pkg;

  localparam logic [7:0] DCR_ADDR_MODEM = 8'h02;
  localparam logic [7:0] DCR_ADDR_DIAG  = 8'h0A;

  // diag_control field positions
  localparam int DCR_DC_AUX_HOLD   = 0;
  localparam int DCR_DC_DISP_EN    = 1;
  localparam int DCR_DC_VID_SEL    = 2;
  localparam int DCR_DC_PARITY     = 3;
  localparam int DCR_DC_ROUTE      = 4;
  localparam int DCR_DC_RING       = 5;
  localparam int DCR_DC_STORE      = 6;
  localparam int DCR_DC_RESTORE    = 7;

  // modem_control_out field positions
  localparam int DCR_MC_SPEED      = 0;
  localparam int DCR_MC_SEC_REQ    = 1;
  localparam int DCR_MC_TERM_RDY_N = 2;
  localparam int DCR_MC_REQ_SEND   = 3;
  localparam int DCR_MC_LAMP_LSB   = 4;

  // aux cpu held, display on, normal routes; line outputs idle, lamps dark
  localparam logic [7:0] DCR_DIAG_RESET  = 8'h03;
  localparam logic [7:0] DCR_MODEM_RESET = 8'hF4;

  typedef struct packed {
    logic ring_ind;
    logic speed_ind;
    logic set_ready;
    logic clear_send;
    logic carrier;
  } dcr_modem_in_t;

  typedef struct packed {
    logic printer_line_in;
    logic video_serial_out;
    logic printer_tx_out;
    logic keys_tx_out;
    logic keys_line_in;
    logic line_tx_out;
    logic line_data_in;
    logic raw_drive_data;
  } dcr_route_in_t;

  typedef struct packed {
    logic printer_rx_in;
    logic keys_rx_in;
    logic line_rx_in;
    logic separator_in;
  } dcr_route_out_t;

endpackage

// ===== dv/dcr_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcr_far_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_step,
  output logic      [26:0] o_far
);
  // lines move only on request, so registered routes can be judged settled
  initial begin
    o_far = 27'h7FFFFFF;
    forever begin
      @(posedge i_ref_clk);
      if (i_step) begin
        o_far <= 27'($urandom);
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/tb_dcr_bank.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dcr_bank;
  logic             clk = 1'b0;
  logic             rst_b = 1'b0;
  logic             step = 1'b0;
  logic             wr = 1'b0;
  logic             rd = 1'b0;
  logic       [7:0] addr = 8'h00;
  logic       [7:0] wdata = 8'h00;
  logic       [7:0] dsh = 8'h03;
  logic       [7:0] msh = 8'hF4;
  logic      [31:0] v;
  logic       [7:0] corner [6] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'hFF, 8'h5A};
  wire logic [26:0] far;
  wire logic [20:0] obs;
  wire logic  [7:0] rdata;
  int               fail_count = 0;
  int               checks = 0;

  always #5 clk = ~clk;

  dcr_far_model i_far (.i_ref_clk(clk), .i_step(step), .o_far(far));

  dcr_bank i_dut (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_io_addr(addr), .i_io_wdata(wdata),
    .i_io_wr(wr), .i_io_rd(rd), .o_io_rdata(rdata),
    .i_factory_straps(far[2:0]), .i_modem(far[7:3]),
    .i_hw_failure_detect_en_n(far[8]), .i_main_cpu_irq_n(far[9]),
    .i_aux_cpu_irq_n(far[10]), .i_serial_irq_n(far[11]),
    .i_test_pin_normal(far[12]), .i_route(far[20:13]),
    .i_printer_baud_clk(far[21]), .i_clk_500k(far[22]),
    .i_master_clk(far[23]), .i_clk_250k(far[24]),
    .i_system_video(far[25]), .i_graphics_video(far[26]),
    .o_aux_cpu_hold(obs[20]), .o_video_out(obs[19]),
    .o_parity_test(obs[18]), .o_settings_store(obs[17]),
    .o_settings_restore(obs[16]), .o_diag_route_select(obs[15]),
    .o_printer_bit_clock(obs[14]), .o_video_clk(obs[13]),
    .o_main_test_in(obs[12]), .o_route(obs[11:8]),
    .o_line_speed_select(obs[7]), .o_line_secondary_req(obs[6]),
    .o_line_terminal_ready_n(obs[5]), .o_line_req_send(obs[4]),
    .o_error_lamp(obs[3:0]));

  function automatic logic [20:0] exp_out(logic [7:0] d, logic [7:0] m,
                                          logic [26:0] f);
    logic [7:0] r;
    r = f[20:13];
    return {d[0], d[1] & (d[2] ? f[26] : f[25]), d[3], d[6], d[7], d[4],
            d[4] ? f[22] : f[21], d[4] ? f[24] : f[23],
            d[4] ? f[11] : f[12],
            d[5] ? r[4] : (d[4] ? r[6] : r[7]), d[5] ? r[5] : r[3],
            d[5] ? r[2] : r[1], d[4] ? r[5] : r[0],
            m[0], m[1], m[2], m[3], m[7:4]};
  endfunction

  // ring indicator sits at status bit 0, carrier at bit 4
  function automatic logic [7:0] exp_stat(logic [26:0] f);
    return {f[10], f[9], f[8], f[3], f[4], f[5], f[6], f[7]};
  endfunction

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic bus_wr(logic [7:0] a, logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
    if (a == dcr_pkg::DCR_ADDR_DIAG) dsh = d;
    else if (a == dcr_pkg::DCR_ADDR_MODEM) msh = d;
  endtask

  // strobe left high so reads can run back to back; caller drops it
  task automatic bus_rd(logic [7:0] a, logic [7:0] exp);
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    check("read data", {24'h0, rdata}, {24'h0, exp});
  endtask

  task automatic settle();
    logic [20:0] e;
    repeat (2) @(posedge clk);
    #1;
    e = exp_out(dsh, msh, far);
    check("cpu hold", 32'(obs[20]), 32'(e[20]));
    check("video", 32'(obs[19]), 32'(e[19]));
    check("controls", 32'(obs[18:15]), 32'(e[18:15]));
    check("clocks", 32'(obs[14:12]), 32'(e[14:12]));
    check("routes", 32'(obs[11:8]), 32'(e[11:8]));
    check("modem lines", 32'(obs[7:0]), 32'(e[7:0]));
  endtask

  initial begin
    #100000;
    fail_count++;
    results();
  end

  initial begin
    v = $urandom(32'h87b0699a);
    repeat (5) @(posedge clk);
    #1 rst_b = 1'b1;
    settle();
    for (int i = 0; i < 6; i++) begin
      bus_wr(8'h0A, corner[i]);
      settle();
      bus_rd(8'h0A, {dsh[7:4], far[2:0], dsh[0]});
      rd = 1'b0;
    end
    for (int i = 0; i < 60; i++) begin
      v = $urandom;
      case (v[1:0])
        2'h0: bus_wr(8'h0A, v[15:8]);
        2'h1: bus_wr(8'h02, v[15:8]);
        2'h2: bus_wr(v[23:16] ^ {7'h0, v[23:16] inside {8'h02, 8'h0A}},
                     v[15:8]);
        default: begin
          step = 1'b1;
          @(posedge clk);
          #1 step = 1'b0;
        end
      endcase
      settle();
      bus_rd(8'h0A, {dsh[7:4], far[2:0], dsh[0]});
      bus_rd(8'h02, exp_stat(far));
      bus_rd(v[31:24] ^ {7'h0, v[31:24] inside {8'h02, 8'h0A}}, 8'h00);
      rd = 1'b0;
    end
    rst_b = 1'b0;
    dsh = 8'h03;
    msh = 8'hF4;
    @(posedge clk);
    #1 rst_b = 1'b1;
    settle();
    results();
  end
endmodule
`default_nettype wire
